/* File: src/ams_pkg.sv */
// package for the auxiliary measurement select register
package ams_pkg;

  // register map and word size
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] AUX_CHANNEL_SELECT_ADDR = 8'h07;

  // field positions
  localparam int RESERVED_BIT = 15;
  localparam int REF2_BIT = 14;
  localparam int EXT_REG_BIT = 13;
  localparam int CORE_SUPPLY_BIT = 12;
  localparam int PIN2_BIT = 8;
  localparam int PIN1_BIT = 7;
  localparam int INT_SUPPLY_BIT = 6;
  localparam int THERM_LSB = 1;
  localparam int THERM_COUNT = 5;
  localparam int PACK_BIT = 0;

  // reset value and writable mask (bits 11..9 read as zero)
  localparam logic [15:0] AUX_RESET = 16'h0001;
  localparam logic [15:0] AUX_WMASK = 16'hF1FF;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ams_req_s;

  // channel enables handed to the measurement sequencer
  typedef struct packed {
    logic ref2_monitor_enable;
    logic ext_regulator_monitor_enable;
    logic core_supply_monitor_enable;
    logic pin2_analog_measure_enable;
    logic pin1_analog_measure_enable;
    logic internal_supply_monitor_enable;
    logic [THERM_COUNT-1:0] thermistor_measure_enable;
    logic pack_voltage_monitor_enable;
  } ams_sel_s;

endpackage : ams_pkg

/* File: src/ams_field_decode.sv */
// decodes the next selection word into channel enables
`timescale 1ns/1ps
`default_nettype none
module ams_field_decode (
  input wire logic [15:0] word,
  output var ams_pkg::ams_sel_s sel
);

  // thermistor enables, gathered before they join the struct
  logic [ams_pkg::THERM_COUNT-1:0] therm;

  // one enable per field
  always_comb
  begin
    sel.thermistor_measure_enable = therm;
    sel.ref2_monitor_enable = word[ams_pkg::REF2_BIT];
    sel.ext_regulator_monitor_enable = word[ams_pkg::EXT_REG_BIT];
    sel.core_supply_monitor_enable = word[ams_pkg::CORE_SUPPLY_BIT];
    sel.pin2_analog_measure_enable = word[ams_pkg::PIN2_BIT];
    sel.pin1_analog_measure_enable = word[ams_pkg::PIN1_BIT];
    sel.internal_supply_monitor_enable = word[ams_pkg::INT_SUPPLY_BIT];
    sel.pack_voltage_monitor_enable = word[ams_pkg::PACK_BIT];
  end

  // thermistor inputs one to five on bits 1 to 5
  genvar gi;
  generate
    for (gi = 0; gi < ams_pkg::THERM_COUNT; gi++)
    begin : g_therm
      assign therm[gi] = word[ams_pkg::THERM_LSB + gi];
    end
  endgenerate

endmodule : ams_field_decode
`default_nettype wire

/* File: src/ams_aux_select.sv */
// auxiliary channel selection register with registered channel enables
//
// Functional notes
// - bit 14 enables second reference voltage measurement; resets to 0.
// - bit 13 enables external regulator output measurement; resets to 0.
// - bit 12 enables core 1.8 V supply measurement; resets to 0.
// - bit 8 enables pin 2 analog measurement; resets to 0.
// - bit 7 enables pin 1 analog measurement; resets to 0.
// - bit 6 enables internal 5.5 V supply measurement; resets to 0.
// - bits 5..1 enable thermistor inputs five..one; all reset to 0.
// - bit 0 enables pack voltage measurement; resets to 1.
`timescale 1ns/1ps
`default_nettype none
module ams_aux_select (
  input wire logic CLOCK,
  input wire logic RST,
  input wire ams_pkg::ams_req_s REQ,
  output logic [15:0] RDATA,
  output logic RVALID,
  output logic [15:0] SELECT_WORD,
  output var ams_pkg::ams_sel_s SEL
);

  // whole state of the module
  typedef struct packed {
    logic [15:0] word; // stored register value
    logic [15:0] rdata; // read answer
    logic rvalid; // read answer strobe
    ams_pkg::ams_sel_s sel; // registered channel enables
  } ams_state_s;

  // registered state and its next value
  ams_state_s state_q;
  ams_state_s state_d;

  // request decode
  logic wr_hit;
  logic rd_hit;
  logic rd_any;

  // write path
  logic [15:0] word_written;
  logic [15:0] word_next;

  // read path
  logic [15:0] word_readable;
  logic [15:0] rdata_next;

  // channel enables decoded from the next word
  ams_pkg::ams_sel_s sel_next;

  // address match, used by read and write paths
  function automatic logic hit(
    input logic [ams_pkg::ADDR_W-1:0] a
  );
    hit = (a == ams_pkg::AUX_CHANNEL_SELECT_ADDR);
  endfunction : hit

  // bit that the host may change, used by write and read paths
  function automatic logic writable(
    input int idx
  );
    writable = ams_pkg::AUX_WMASK[idx];
  endfunction : writable

  // strobes that hit this register, and the read strobe at any address
  always_comb
  begin
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rd_any = REQ.rd;
    if (REQ.wr)
    begin
      wr_hit = hit(REQ.addr);
    end
    if (REQ.rd)
    begin
      rd_hit = hit(REQ.addr);
    end
  end

  // per-bit paths; read-only bits neither take data nor show it
  genvar bi;
  generate
    for (bi = 0; bi < ams_pkg::DATA_W; bi++)
    begin : g_bit
      if (writable(bi))
      begin : g_rw
        assign word_written[bi] = REQ.wdata[bi];
        assign word_readable[bi] = state_q.word[bi];
      end
      else
      begin : g_ro
        assign word_written[bi] = 1'b0;
        assign word_readable[bi] = 1'b0;
      end
    end
  endgenerate

  // write lands at the edge that takes it; other addresses leave the word
  always_comb
  begin
    word_next = state_q.word;
    if (wr_hit)
    begin
      word_next = word_written;
    end
    else
    begin
      // unmapped or no write: word holds
      word_next = state_q.word;
    end
  end

  // field decode of the next word, so enables move with the stored word
  ams_field_decode u_decode (
    .word(word_next),
    .sel(sel_next)
  );

  // read answer; a same-cycle write is not seen, unmapped reads give zero
  always_comb
  begin
    rdata_next = 16'h0000;
    if (rd_hit)
    begin
      rdata_next = word_readable;
    end
    else
    begin
      // unmapped read still answers, with zero
      rdata_next = 16'h0000;
    end
  end

  // next state: stored word, read answer, enables
  always_comb
  begin
    state_d = state_q;
    // stored word and its enables move together
    state_d.word = word_next;
    state_d.sel = sel_next;
    // any read strobe is answered one cycle later
    state_d.rvalid = rd_any;
    state_d.rdata = rdata_next;
  end

  // state register; every enable starts from its reset bit
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      // stored word: only the pack enable set
      state_q.word <= ams_pkg::AUX_RESET;
      // no read answer pending
      state_q.rdata <= 16'h0000;
      state_q.rvalid <= 1'b0;
      // reference and supply monitors off
      state_q.sel.ref2_monitor_enable <=
        ams_pkg::AUX_RESET[ams_pkg::REF2_BIT];
      state_q.sel.ext_regulator_monitor_enable <=
        ams_pkg::AUX_RESET[ams_pkg::EXT_REG_BIT];
      state_q.sel.core_supply_monitor_enable <=
        ams_pkg::AUX_RESET[ams_pkg::CORE_SUPPLY_BIT];
      // analog pin measurements off
      state_q.sel.pin2_analog_measure_enable <=
        ams_pkg::AUX_RESET[ams_pkg::PIN2_BIT];
      state_q.sel.pin1_analog_measure_enable <=
        ams_pkg::AUX_RESET[ams_pkg::PIN1_BIT];
      // internal supply and thermistors off
      state_q.sel.internal_supply_monitor_enable <=
        ams_pkg::AUX_RESET[ams_pkg::INT_SUPPLY_BIT];
      state_q.sel.thermistor_measure_enable <=
        ams_pkg::AUX_RESET[ams_pkg::THERM_LSB +: ams_pkg::THERM_COUNT];
      // pack voltage measured by default
      state_q.sel.pack_voltage_monitor_enable <=
        ams_pkg::AUX_RESET[ams_pkg::PACK_BIT];
    end
    else
    begin
      // all state advances on every edge
      state_q <= state_d;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = state_q.rdata;
  assign RVALID = state_q.rvalid;
  assign SELECT_WORD = state_q.word;
  assign SEL = state_q.sel;

endmodule : ams_aux_select
`default_nettype wire

/* File: sim/ams_aux_select_sva.sv */
// port assertions for the aux select register
`timescale 1ns/1ps
`default_nettype none
module ams_aux_select_sva (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic RVALID,
  input wire logic [15:0] RDATA,
  input wire ams_pkg::ams_req_s REQ,
  input wire ams_pkg::ams_sel_s SEL
);
  logic w_q;
  logic [15:0] d_q;
  wire logic [11:0] s = SEL;
  // remember a write taken at the last edge and its data
  always_ff @(posedge CLOCK) w_q <= !RST && REQ.wr && REQ.addr == 8'h07;
  always_ff @(posedge CLOCK) d_q <= REQ.wdata;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_b14_copy: assert property (w_q |-> s[11] == d_q[14]) else $error("b14");
  a_b13_copy: assert property (w_q |-> s[10] == d_q[13]) else $error("b13");
  a_b12_copy: assert property (w_q |-> s[9] == d_q[12]) else $error("b12");
  a_pin_copy: assert property (w_q |-> s[8:7] == d_q[8:7]) else $error("pin");
  a_b6_copy: assert property (w_q |-> s[6] == d_q[6]) else $error("b6");
  a_therm_copy: assert property (w_q |-> s[5:1] == d_q[5:1]) else $error("th");
  a_pack_copy: assert property (w_q |-> s[0] == d_q[0]) else $error("b0");
  a_gap_zero: assert property (RVALID |-> RDATA[11:9] == 3'h0) else $error("gap");
endmodule : ams_aux_select_sva
bind ams_aux_select ams_aux_select_sva chk (.CLOCK(CLOCK), .RST(RST), .RVALID(RVALID),
  .RDATA(RDATA), .REQ(REQ), .SEL(SEL));
`default_nettype wire

/* File: sim/ams_host.sv */
// host model driving the register request port
`timescale 1ns/1ps
`default_nettype none
module ams_host (
  input wire logic CLOCK, input wire logic RVALID, input wire logic [15:0] RDATA,
  output var ams_pkg::ams_req_s REQ);
  logic [3:0] cfg = 4'h0; // pin output-disable and input-enable shadow
  initial REQ = '0;
  // one write or read, then both strobes drop and the address and data lines show the inverse of the last value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    if (w && (d[8] | d[7])) cfg = 4'hF;
    @(posedge CLOCK) #1 REQ = '{w, !w, a, d};
    @(posedge CLOCK) #1 REQ = '{1'b0, 1'b0, ~a, ~d};
    q = (RVALID === 1'b1) ? RDATA : 'x;
  endtask : xfer
endmodule : ams_host
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the aux select register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("Error %0t %h %h", $time, a, e); end end
module testbench;
  logic CLOCK = 1'b0, RST = 1'b1, RVALID;
  logic [15:0] RDATA, SELECT_WORD, v;
  ams_pkg::ams_req_s REQ;
  ams_pkg::ams_sel_s SEL;
  int fails = 0, check_count = 0;
  always #4 CLOCK = ~CLOCK;
  ams_aux_select dut (.CLOCK(CLOCK), .RST(RST), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID),
    .SELECT_WORD(SELECT_WORD), .SEL(SEL));
  ams_host host (.CLOCK(CLOCK), .RVALID(RVALID), .RDATA(RDATA), .REQ(REQ));
  task automatic complete_run();
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // write d at a, then word, enables and read-back must equal x
  task automatic put(input logic [7:0] a, input logic [15:0] d, x);
    host.xfer(1'b1, a, d, v);
    host.xfer(1'b0, 8'h07, 16'h0000, v);
    `CHK({SELECT_WORD, SEL, v}, {x, x[14:12], x[8:0], x})
  endtask : put
  // reset value, unmapped write, each bit alone, all ones, unmapped read
  initial
  begin
    repeat (5) @(posedge CLOCK);
    #1 RST = 1'b0;
    put(8'h08, 16'hFFFF, 16'h0001);
    for (int i = 0; i < 16; i++) put(8'h07, 16'h1 << i, (16'h1 << i) & 16'hF1FF);
    put(8'h07, 16'hFFFF, 16'hF1FF);
    // reset again in mid-run: every enable back to its reset value
    RST = 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 RST = 1'b0;
    `CHK({SELECT_WORD, SEL}, {16'h0001, 12'h001})
    put(8'h07, 16'h0000, 16'h0000);
    host.xfer(1'b0, 8'h08, 16'h0000, v);
    `CHK(v, 16'h0000)
    complete_run();
  end
endmodule : testbench
`default_nettype wire
